// ===== include/osir_params.svh
// Register offsets, field positions and reset values of the sensor register map
`ifndef OSIR_PARAMS_SVH
`define OSIR_PARAMS_SVH
`define OSIR_A_FLAGS_MAIN 8'h00
`define OSIR_A_FLAGS_TEMP 8'h01
`define OSIR_A_MASK_MAIN 8'h02
`define OSIR_A_MASK_TEMP 8'h03
`define OSIR_A_QWR 8'h04
`define OSIR_A_LOST 8'h05
`define OSIR_A_QRD 8'h06
`define OSIR_A_QDATA 8'h07
`define OSIR_A_QSETUP 8'h08
`define OSIR_A_OPCTL 8'h09
`define OSIR_A_OXSETUP 8'h0a
`define OSIR_A_RSV0B 8'h0b
`define OSIR_A_EM1 8'h0c
`define OSIR_A_EM2 8'h0d
`define OSIR_A_EM3 8'h0e
`define OSIR_A_EM4 8'h0f
`define OSIR_A_SLOT12 8'h11
`define OSIR_A_SLOT34 8'h12
`define OSIR_A_RSVFF_LO 8'h13
`define OSIR_A_RSVFF_HI 8'h17
`define OSIR_A_TWHOLE 8'h1f
`define OSIR_A_CHIP_TEMP_FRAC 8'h20
`define OSIR_A_TCTL 8'h21
`define OSIR_A_REV 8'hfe
`define OSIR_A_PID 8'hff
`define OSIR_B_FULL 7
`define OSIR_B_SAMPLE 6
`define OSIR_B_AMBIENT 5
`define OSIR_B_POWER 0
`define OSIR_B_TEMP 1
`define OSIR_RST_ZERO 8'h00
`define OSIR_RST_RSVFF 8'hff
`endif

// ===== include/osir_pkg.sv
// Types shared by the sensor interrupt and register block
package osir_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } osir_bus_t;
  typedef struct packed {
    logic almost_full;
    logic new_sample;
    logic ambient_limit;
    logic power_up;
    logic temp_done;
  } osir_evt_t;
  typedef enum logic {OSIR_BOOT, OSIR_RUN} osir_phase_t;
endpackage

// ===== rtl/osir_regmap.sv
// Interrupt flags, masks and register file of the optical sensor
`timescale 1ns/1ps
`default_nettype none
`include "osir_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Interrupt pin held low until cleared
// - Almost-full flag bit 7 cleared by status-1 read
// - Sample-ready flag bit 6 on each new sample
// - Sample-ready cleared by status-1 or data read
// - Ambient overflow flag bit 5, status-1 read clears
// - Power-good flag bit 0 after power-up
// - Temperature-ready flag bit 1 of status 2
// - Temp flag cleared by status-2 or fraction read
// - Revision register returns fixed revision code
// - All sources maskable except power-good
// - Status read zeroes bits, releases pin if no other enabled or power-good flag is set
module osir_regmap import osir_pkg::*; #(
  parameter logic [7:0] REVISION_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PRODUCT_CODE = 8'ha5 // Arbitrary value
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire osir_bus_t bus,
  input wire osir_evt_t evt,
  output logic [7:0] rdata,
  output logic irq_pin_o,
  output logic irq_pin_oe_n
);

  typedef struct packed {
    osir_phase_t phase;
    logic [7:0] flags_main;
    logic [7:0] flags_temp;
    logic [7:0] mask_main;
    logic [7:0] mask_temp;
    logic [7:0] qwr;
    logic [7:0] lost;
    logic [7:0] qrd;
    logic [7:0] qdata;
    logic [7:0] qsetup;
    logic [7:0] opctl;
    logic [7:0] oxsetup;
    logic [7:0] rsv0b;
    logic [7:0] em1;
    logic [7:0] em2;
    logic [7:0] em3;
    logic [7:0] em4;
    logic [7:0] slot12;
    logic [7:0] slot34;
    logic [7:0] tctl;
    logic [7:0] rdata;
    logic irq_oe_n;
  } osir_state_t;

  osir_state_t st_r;
  osir_state_t st_nxt;
  logic rd_main;
  logic rd_temp;
  logic rd_data;
  logic rd_frac;
  logic irq_want;

  ////////////////////////////////////////////////////////////////////////////
  // Read strobe aimed at one register
  function automatic logic read_at(input osir_bus_t b,
                                   input logic [7:0] a);
    return b.rd && b.addr == a;
  endfunction

  // Read strobes that clear flags
  assign rd_main = read_at(bus, `OSIR_A_FLAGS_MAIN);
  assign rd_temp = read_at(bus, `OSIR_A_FLAGS_TEMP);
  assign rd_data = read_at(bus, `OSIR_A_QDATA);
  assign rd_frac = read_at(bus, `OSIR_A_CHIP_TEMP_FRAC);

  // Register read mux
  function automatic logic [7:0] read_mux(input osir_state_t s,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = `OSIR_RST_ZERO;
    case (a)
      `OSIR_A_FLAGS_MAIN: v = s.flags_main;
      `OSIR_A_FLAGS_TEMP: v = s.flags_temp;
      `OSIR_A_MASK_MAIN: v = s.mask_main;
      `OSIR_A_MASK_TEMP: v = s.mask_temp;
      `OSIR_A_QWR: v = s.qwr;
      `OSIR_A_LOST: v = s.lost;
      `OSIR_A_QRD: v = s.qrd;
      `OSIR_A_QDATA: v = s.qdata;
      `OSIR_A_QSETUP: v = s.qsetup;
      `OSIR_A_OPCTL: v = s.opctl;
      `OSIR_A_OXSETUP: v = s.oxsetup;
      `OSIR_A_RSV0B: v = s.rsv0b;
      `OSIR_A_EM1: v = s.em1;
      `OSIR_A_EM2: v = s.em2;
      `OSIR_A_EM3: v = s.em3;
      `OSIR_A_EM4: v = s.em4;
      `OSIR_A_SLOT12: v = s.slot12;
      `OSIR_A_SLOT34: v = s.slot34;
      `OSIR_A_TCTL: v = s.tctl;
      `OSIR_A_REV: v = REVISION_CODE;
      `OSIR_A_PID: v = PRODUCT_CODE;
      default: begin
        if (a >= `OSIR_A_RSVFF_LO && a <= `OSIR_A_RSVFF_HI) begin
          v = `OSIR_RST_RSVFF;
        end
      end
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = bus.rd ? read_mux(st_r, bus.addr) : st_r.rdata;
    // Status reads zero the whole register; new events win
    if (rd_main) begin
      st_nxt.flags_main = `OSIR_RST_ZERO;
    end
    if (rd_temp || rd_frac) begin
      st_nxt.flags_temp = `OSIR_RST_ZERO;
    end
    if (rd_data) begin
      st_nxt.flags_main[`OSIR_B_SAMPLE] = 1'b0;
    end
    if (evt.almost_full) begin
      st_nxt.flags_main[`OSIR_B_FULL] = 1'b1;
    end
    if (evt.new_sample) begin
      st_nxt.flags_main[`OSIR_B_SAMPLE] = 1'b1;
    end
    if (evt.ambient_limit) begin
      st_nxt.flags_main[`OSIR_B_AMBIENT] = 1'b1;
    end
    if (evt.temp_done) begin
      st_nxt.flags_temp[`OSIR_B_TEMP] = 1'b1;
    end
    // Power-good after reset release or a supply recovery
    if (st_r.phase == OSIR_BOOT || evt.power_up) begin
      st_nxt.flags_main[`OSIR_B_POWER] = 1'b1;
    end
    st_nxt.phase = OSIR_RUN;
    // Writable registers
    if (bus.wr) begin
      case (bus.addr)
        `OSIR_A_MASK_MAIN: st_nxt.mask_main = bus.wdata;
        `OSIR_A_MASK_TEMP: st_nxt.mask_temp = bus.wdata;
        `OSIR_A_QWR: st_nxt.qwr = bus.wdata;
        `OSIR_A_LOST: st_nxt.lost = bus.wdata;
        `OSIR_A_QRD: st_nxt.qrd = bus.wdata;
        `OSIR_A_QDATA: st_nxt.qdata = bus.wdata;
        `OSIR_A_QSETUP: st_nxt.qsetup = bus.wdata;
        `OSIR_A_OPCTL: st_nxt.opctl = bus.wdata;
        `OSIR_A_OXSETUP: st_nxt.oxsetup = bus.wdata;
        `OSIR_A_RSV0B: st_nxt.rsv0b = bus.wdata;
        `OSIR_A_EM1: st_nxt.em1 = bus.wdata;
        `OSIR_A_EM2: st_nxt.em2 = bus.wdata;
        `OSIR_A_EM3: st_nxt.em3 = bus.wdata;
        `OSIR_A_EM4: st_nxt.em4 = bus.wdata;
        `OSIR_A_SLOT12: st_nxt.slot12 = bus.wdata;
        `OSIR_A_SLOT34: st_nxt.slot34 = bus.wdata;
        `OSIR_A_TCTL: st_nxt.tctl = bus.wdata;
        default: st_nxt.tctl = st_nxt.tctl;
      endcase
    end
    // Sources enabled in the mask plus unmaskable power-good drive the pin
    irq_want = |(st_nxt.flags_main & st_nxt.mask_main
                 & ~(8'h01 << `OSIR_B_POWER))
               || |(st_nxt.flags_temp & st_nxt.mask_temp)
               || st_nxt.flags_main[`OSIR_B_POWER];
    st_nxt.irq_oe_n = ~irq_want;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.phase <= OSIR_BOOT;
      st_r.irq_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign irq_pin_o = 1'b0; // Open drain: only ever pulls low
  assign irq_pin_oe_n = st_r.irq_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_full_evt;
    evt.almost_full && !rd_main;
  endsequence
  sequence s_main_read;
    rd_main && !(|evt);
  endsequence

  AST_PIN_FOLLOWS: assert property (@(posedge clock) disable iff (!arst_n)
    (st_r.flags_main[`OSIR_B_POWER] |-> !irq_pin_oe_n))
    else $error("Pin released while power-good flag set");
  AST_FULL_SET: assert property (@(posedge clock) disable iff (!arst_n)
    s_full_evt |=> st_r.flags_main[`OSIR_B_FULL])
    else $error("Almost-full flag not set");
  AST_SAMPLE_SET: assert property (@(posedge clock) disable iff (!arst_n)
    evt.new_sample |=> st_r.flags_main[`OSIR_B_SAMPLE])
    else $error("Sample flag not set");
  AST_SAMPLE_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    (rd_data && !evt.new_sample) |=> !st_r.flags_main[`OSIR_B_SAMPLE])
    else $error("Sample flag not cleared by data read");
  AST_AMB_SET: assert property (@(posedge clock) disable iff (!arst_n)
    evt.ambient_limit |=> st_r.flags_main[`OSIR_B_AMBIENT])
    else $error("Ambient flag not set");
  AST_PWR_SET: assert property (@(posedge clock) disable iff (!arst_n)
    evt.power_up |=> st_r.flags_main[`OSIR_B_POWER] && !irq_pin_oe_n)
    else $error("Power-good not raised");
  AST_TEMP_SET: assert property (@(posedge clock) disable iff (!arst_n)
    evt.temp_done |=> st_r.flags_temp[`OSIR_B_TEMP])
    else $error("Temperature flag not set");
  AST_TEMP_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    ((rd_temp || rd_frac) && !evt.temp_done) |=> st_r.flags_temp == 8'h00)
    else $error("Temperature flag not cleared");
  AST_REV: assert property (@(posedge clock) disable iff (!arst_n)
    (bus.rd && bus.addr == `OSIR_A_REV) |=> rdata == REVISION_CODE)
    else $error("Revision read wrong");
  AST_MASKED: assert property (@(posedge clock) disable iff (!arst_n)
    (st_r.mask_main == 8'h00 && st_r.mask_temp == 8'h00
     && !st_r.flags_main[`OSIR_B_POWER]) |-> irq_pin_oe_n)
    else $error("Masked source drove the pin");
  AST_READ_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    s_main_read |=> st_r.flags_main == 8'h00)
    else $error("Status read did not zero flags");
  AST_ENABLED: assert property (@(posedge clock) disable iff (!arst_n)
    (|(st_r.flags_temp & st_r.mask_temp)) |-> !irq_pin_oe_n)
    else $error("Enabled flag did not drive pin");

  ////////////////////////////////////////////////////////////////////////////
  // Clearing and pin release
  // A read in the same cycle as an event keeps the flag, so both main
  // read sequences leave out every event, and s_clean_main_read also the boot cycle
  sequence s_clean_main_read;
    rd_main && !(|evt) && !bus.wr && st_r.phase == OSIR_RUN;
  endsequence
  sequence s_pin_low_idle;
    !irq_pin_oe_n && !bus.rd && !bus.wr;
  endsequence
  sequence s_rsvff_read;
    bus.rd && bus.addr >= `OSIR_A_RSVFF_LO && bus.addr <= `OSIR_A_RSVFF_HI;
  endsequence

  AST_FULL_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    s_main_read |=> !st_r.flags_main[`OSIR_B_FULL])
    else $error("Almost-full flag not cleared");
  AST_SAMPLE_MAIN_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    s_main_read |=> !st_r.flags_main[`OSIR_B_SAMPLE])
    else $error("Sample flag not cleared by status read");
  AST_AMB_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    s_main_read |=> !st_r.flags_main[`OSIR_B_AMBIENT])
    else $error("Ambient flag not cleared");
  AST_TEMP_FRAC_CLR: assert property (@(posedge clock) disable iff (!arst_n)
    (rd_frac && !evt.temp_done) |=> !st_r.flags_temp[`OSIR_B_TEMP])
    else $error("Fraction read did not clear temperature flag");
  AST_PIN_RELEASE: assert property (@(posedge clock) disable iff (!arst_n)
    s_clean_main_read ##0 !(|(st_r.flags_temp & st_r.mask_temp))
    |=> irq_pin_oe_n)
    else $error("Status read did not release pin");
  AST_PIN_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    s_pin_low_idle |=> !irq_pin_oe_n)
    else $error("Pin released without a clear");

  ////////////////////////////////////////////////////////////////////////////
  // Masking and power-good
  AST_MASK_WR: assert property (@(posedge clock) disable iff (!arst_n)
    (bus.wr && bus.addr == `OSIR_A_MASK_MAIN)
    |=> st_r.mask_main == $past(bus.wdata))
    else $error("Mask write lost");
  AST_TEMP_MASKED: assert property (@(posedge clock) disable iff (!arst_n)
    (st_r.mask_temp == 8'h00 && !(|(st_r.flags_main & st_r.mask_main))
     && !st_r.flags_main[`OSIR_B_POWER]) |-> irq_pin_oe_n)
    else $error("Masked temperature flag drove the pin");
  AST_BOOT_PWR: assert property (@(posedge clock) disable iff (!arst_n)
    st_r.phase == OSIR_BOOT |=> st_r.flags_main[`OSIR_B_POWER])
    else $error("Power-good not raised after reset");
  AST_FULL_PIN: assert property (@(posedge clock) disable iff (!arst_n)
    (st_r.flags_main[`OSIR_B_FULL] && st_r.mask_main[`OSIR_B_FULL])
    |-> !irq_pin_oe_n)
    else $error("Enabled almost-full flag did not drive pin");
  AST_AMB_PIN: assert property (@(posedge clock) disable iff (!arst_n)
    (st_r.flags_main[`OSIR_B_AMBIENT] && st_r.mask_main[`OSIR_B_AMBIENT])
    |-> !irq_pin_oe_n)
    else $error("Enabled ambient flag did not drive pin");

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // Read data must stand until the next read, the host may fetch it late
  AST_RDATA_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    !bus.rd |=> $stable(rdata))
    else $error("Read data changed without a read");
  AST_RSVFF: assert property (@(posedge clock) disable iff (!arst_n)
    s_rsvff_read |=> rdata == `OSIR_RST_RSVFF)
    else $error("Reserved block read wrong");

endmodule
`default_nettype wire

// ===== test/osir_host.sv
// Host model issuing register reads and writes to the sensor
`timescale 1ns/1ps
`default_nettype none
module osir_host import osir_pkg::*; (
  input wire logic clock,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe_n,
  output var osir_bus_t bus,
  output logic irq_line
);
  // Pulled-up interrupt wire, low only while the device drives it
  assign irq_line = irq_pin_oe_n ? 1'b1 : irq_pin_o;
  initial bus = '0;
  // One strobe held over its sampling edge, lines scrambled when idle
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clock);
    #1;
    bus = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clock);
    #1;
    bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the sensor interrupt and register block
`timescale 1ns/1ps
`default_nettype none
module testbench import osir_pkg::*;;
  typedef struct packed {logic c; logic [7:0] d; logic p;} osir_exp_t;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  osir_evt_t evt = '0;
  osir_bus_t bus;
  logic [7:0] rdata, v;
  logic pin_o, oe_n, irq, was;
  osir_exp_t q[$];
  osir_exp_t e;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] seed = 32'd10;
  logic [7:0] ra[8] = '{8'h03, 8'h04, 8'h07, 8'h10, 8'h13, 8'h17, 8'h18,
                        8'h21};
  logic [7:0] wa[6] = '{8'h08, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h06};
  always #2.5 clock = ~clock;
  // Identity codes are arbitrary
  osir_regmap #(.REVISION_CODE(8'h3c), .PRODUCT_CODE(8'hc3)) osir_regmap_i (
    .clock(clock), .arst_n(arst_n), .bus(bus), .evt(evt), .rdata(rdata),
    .irq_pin_o(pin_o), .irq_pin_oe_n(oe_n));
  osir_host osir_host_i (.clock(clock), .irq_pin_o(pin_o),
    .irq_pin_oe_n(oe_n), .bus(bus), .irq_line(irq));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic bad(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic rd(input logic [7:0] a, input logic c, input logic [7:0] d,
                    input logic p);
    q.push_back('{c, d, p});
    osir_host_i.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    osir_host_i.xfer(1'b1, a, d);
  endtask
  task automatic pin(input logic p);
    checked++;
    if (irq !== p) bad("interrupt line");
  endtask
  task automatic ev(input osir_evt_t x);
    @(posedge clock);
    #1;
    evt = x;
    @(posedge clock);
    #1;
    evt = '0;
  endtask
  task automatic rst();
    arst_n = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    arst_n = 1'b1;
    @(posedge clock);
    #1;
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Oldest expected read result compared when read data lands
  always @(posedge clock) begin
    was = bus.rd;
    #2;
    if (was) begin
      e = q.pop_front();
      checked++;
      if ((e.c && rdata !== e.d) || irq !== e.p) bad("read data or line");
    end
  end
  // Watchdog
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    rst();
    pin(1'b0);
    rd(8'h00, 1, 8'h01, 1);
    rd(8'h00, 1, 8'h00, 1);
    foreach (ra[i]) begin
      v = (ra[i] > 8'h12 && ra[i] < 8'h18) ? 8'hff : 8'h00;
      rd(ra[i], 1, v, 1);
    end
    foreach (wa[i]) begin
      v = rnd();
      wr(wa[i], v);
      rd(wa[i], 1, v, 1);
    end
    wr(8'h1f, rnd());
    rd(8'h1f, 1, 8'h00, 1);
    $display("test 1 done");
    ev('{almost_full: 1, new_sample: 1, ambient_limit: 1, default: 0});
    pin(1'b1);
    rd(8'h00, 1, 8'he0, 1);
    for (int i = 5; i < 8; i++) begin
      wr(8'h02, 8'h01 << i);
      ev(osir_evt_t'(5'h01 << (i - 3)));
      repeat (3) @(posedge clock);
      pin(1'b0);
      if (i == 6) rd(8'h07, 0, 8'h00, 1);
      rd(8'h00, 1, (i == 6) ? 8'h00 : 8'h01 << i, 1);
    end
    $display("test 2 done");
    wr(8'h03, 8'h02);
    ev('{temp_done: 1, default: 0});
    pin(1'b0);
    rd(8'h20, 0, 8'h00, 1);
    ev('{temp_done: 1, default: 0});
    rd(8'h01, 1, 8'h02, 1);
    rd(8'h01, 1, 8'h00, 1);
    wr(8'h02, 8'h00);
    ev('{power_up: 1, default: 0});
    pin(1'b0);
    rd(8'h00, 1, 8'h01, 1);
    rd(8'hfe, 1, 8'h3c, 1);
    rd(8'hff, 1, 8'hc3, 1);
    $display("test 3 done");
    wr(8'h02, 8'he0);
    rst();
    rd(8'h02, 1, 8'h00, 0);
    rd(8'h00, 1, 8'h01, 1);
    $display("test 4 done");
    repeat (2) @(posedge clock);
    summarize();
  end
endmodule
`default_nettype wire
